// ===== ohb_map.svh
// constants for the oled host bus front end
// ****************************************************************
// What this block does
// (R1) decode three straps into six bus modes
// (R2) parallel and serial work only while chip select is low
// (R3) host holds chip select low in i2c
// (R4) reset pin low runs full initialization
// (R5) data/command high means display data
// (R6) data/command low writes command register
// (R7) data/command pin is i2c address lsb
// (R8) host ties data/command low in serial
// (R9) 6800 read/write pin gives transfer direction
// (R10) 8080 write strobe low starts write
// (R11) host ties write pin low serial/i2c
// (R12) serial clock on d0, data on d1
// (R13) i2c sda on d1+d2, scl on d0
// (R14) font rom chosen by two straps
// (R15) row scan direction from row strap
// (R16) column mapping direction from column strap
// (R17) 6800 enable high, 8080 read low
// (R18) 4-bit modes send two nibbles per byte
// ****************************************************************
`ifndef OHB_MAP_SVH
`define OHB_MAP_SVH
`define OHB_BS_SERIAL 3'h0
`define OHB_BS_I2C 3'h2
`define OHB_I2C_ADDR_HI 6'h1e
`define OHB_I2C_DC_BIT 6
`define OHB_I2C_ACK_A 5'h09
`define OHB_I2C_ACK_B 5'h12
`define OHB_I2C_ACK_C 5'h1b
`define OHB_I2C_STOP 5'h1c
`define OHB_SER_LAST 4'h8
`define OHB_ROW_LAST 5'h1f
`define OHB_COL_LAST 7'h63
`define OHB_FONT_C_CODE 2'h2
`define OHB_FONT_SW_CODE 2'h3
`define OHB_HDIV_LAST 2'h3
`endif

// ===== ohb_pkg.sv
// types and mode decoding shared by both ends
package ohb_pkg;
  // i2c receive phases of the device end
  typedef enum logic [3:0] {
    OHB_I_IDLE = 4'h1,
    OHB_I_ADDR = 4'h2,
    OHB_I_CTRL = 4'h4,
    OHB_I_DATA = 4'h8
  } ohb_i2c_t;
  // host sequencer states
  typedef enum logic [4:0] {
    OHB_H_IDLE = 5'h01,
    OHB_H_PAR = 5'h02,
    OHB_H_SER = 5'h04,
    OHB_H_I2C = 5'h08,
    OHB_H_DONE = 5'h10
  } ohb_hst_t;
  // 6800 parallel, 8 or 4 bit
  function automatic logic ohb_is_68(input logic [2:0] bs);
    return bs[2:1] == 2'h2;
  endfunction
  // 8080 parallel, 8 or 4 bit
  function automatic logic ohb_is_80(input logic [2:0] bs);
    return bs[2:1] == 2'h3;
  endfunction
  // 4-bit parallel variants
  function automatic logic ohb_is_nib(input logic [2:0] bs);
    return bs[2] & bs[0];
  endfunction
endpackage

// ===== ohb_if.sv
// pin bundle joining the microcontroller end and the display end
`timescale 1ns/1ps
interface ohb_if;
  logic cs_n;
  logic data_cmd_sel;
  logic rw_wr_n;
  logic e_rd_n;
  logic reset_in_n;
  logic [7:0] h_out;
  logic [7:0] h_oe;
  logic [7:0] v_out;
  logic [7:0] v_oe;
  logic [7:0] lvl;
  logic sda;
  // an undriven data line floats high through its pull-up
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pad
      assign lvl[i] = (h_oe[i] ? h_out[i] : 1'b1) & (v_oe[i] ? v_out[i] : 1'b1);
    end
  endgenerate
  // d1 and d2 joined on the board form sda
  assign sda = lvl[1] & lvl[2];
  modport dev (
    input cs_n, data_cmd_sel, rw_wr_n, e_rd_n, reset_in_n, lvl, sda,
    output v_out, v_oe
  );
  modport host (
    output cs_n, data_cmd_sel, rw_wr_n, e_rd_n, reset_in_n, h_out, h_oe,
    input lvl, sda
  );
endinterface

// ===== ohb_host.sv
// microcontroller end: drives one byte transfer on the selected bus
`timescale 1ns/1ps
`include "ohb_map.svh"
module ohb_host (
  input wire logic clock, // 40 mhz system clock
  input wire logic rst, // synchronous reset, high
  ohb_if.host pins, // display bus pins
  input wire logic [2:0] bus_mode, // same code as the device straps
  input wire logic start, // pulse: begin a transfer
  input wire logic is_data, // 1 display data, 0 command
  input wire logic is_read, // parallel read
  input wire logic [7:0] wbyte, // byte to write
  input wire logic slave_addr_lsb, // i2c address lsb
  input wire logic dev_reset, // hold the display in initialization
  output logic busy, // transfer running
  output logic done, // pulse: transfer finished
  output logic [7:0] rbyte, // byte read back
  output logic nack // i2c acknowledge missing
);
  ohb_pkg::ohb_hst_t st_reg;
  logic [1:0] div_reg;
  logic [1:0] ph_reg;
  logic [4:0] cnt_reg;
  logic [26:0] sh_reg;
  logic [2:0] mode_reg;
  logic rd_reg;
  logic dc_reg;
  logic done_reg;
  logic nack_reg;
  logic [7:0] rbyte_reg;
  logic cs_n_reg, dcp_reg, rw_reg, e_reg, rst_n_reg;
  logic [7:0] hout_reg, hoe_reg;
  // ****************************************************************
  // decode and pin values
  // ****************************************************************
  wire [2:0] md = (st_reg == ohb_pkg::OHB_H_IDLE) ? bus_mode : mode_reg;
  wire m68 = ohb_pkg::ohb_is_68(md);
  wire m80 = ohb_pkg::ohb_is_80(md);
  wire nib = ohb_pkg::ohb_is_nib(md);
  wire mi2c = md == `OHB_BS_I2C;
  wire mser = md == `OHB_BS_SERIAL;
  wire tick = div_reg == `OHB_HDIV_LAST;
  wire in_par = st_reg == ohb_pkg::OHB_H_PAR;
  wire in_ser = st_reg == ohb_pkg::OHB_H_SER;
  wire in_i2c = st_reg == ohb_pkg::OHB_H_I2C;
  wire stb = in_par & (ph_reg == 2'h1 | ph_reg == 2'h2);
  wire [3:0] nib_val = cnt_reg[0] ? sh_reg[3:0] : sh_reg[7:4];
  wire [7:0] par_out = nib ? {nib_val, 4'h0} : sh_reg[7:0];
  wire [7:0] par_oe = rd_reg ? 8'h00 : (nib ? 8'hf0 : 8'hff);
  wire bit_slot = cnt_reg != 5'h00 & cnt_reg != `OHB_I2C_STOP;
  wire scl = bit_slot ? ph_reg[0] : (cnt_reg == 5'h00 | ph_reg != 2'h0);
  wire sda = bit_slot ? sh_reg[26] : (cnt_reg == 5'h00 ? ~ph_reg[0] : ph_reg == 2'h2);
  wire ack_slot = cnt_reg == `OHB_I2C_ACK_A | cnt_reg == `OHB_I2C_ACK_B |
                  cnt_reg == `OHB_I2C_ACK_C;
  // chip select: low through each access, always low in i2c
  wire cs_n_next = ~(in_par | in_ser | mi2c); // R2 R3
  // data/command: i2c address bit, tied low for serial
  wire dcp_next = mi2c ? slave_addr_lsb : (mser ? 1'b0 : dc_reg); // R7 R8
  // direction/write pin: 6800 direction, 8080 write strobe, else low
  wire rw_next = m68 ? (in_par & rd_reg) : (m80 ? ~(stb & ~rd_reg) : 1'b0); // R9 R10 R11
  // enable / read strobe
  wire e_next = m68 ? stb : (m80 ? ~(stb & rd_reg) : 1'b0); // R17
  // serial clock on d0 and data on d1; i2c scl push-pull, sda open drain
  wire [7:0] hout_next = in_par ? par_out :
                         in_ser ? {6'h00, sh_reg[26], ph_reg[0]} : // R12
                         mi2c ? {7'h00, in_i2c ? scl : 1'b1} : 8'h00; // R13
  wire [7:0] hoe_next = in_par ? par_oe : in_ser ? 8'h03 :
                        mi2c ? {6'h00, in_i2c & ~sda, 1'b1} : 8'h00;
  // i2c frame: address + write, control byte, payload, with ack slots
  wire [26:0] i2c_frame = {`OHB_I2C_ADDR_HI, slave_addr_lsb, 1'b0, 1'b1,
                           1'b0, is_data, 6'h00, 1'b1, wbyte, 1'b1};
  // ****************************************************************
  // sequencer; the bus states advance on the divider tick, idle and done do not wait for it
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= ohb_pkg::OHB_H_IDLE;
      div_reg <= 2'h0;
      ph_reg <= 2'h0;
      cnt_reg <= 5'h00;
      sh_reg <= 27'h0;
      mode_reg <= 3'h0;
      rd_reg <= 1'b0;
      dc_reg <= 1'b0;
      nack_reg <= 1'b0;
      rbyte_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 2'h1;
      unique case (st_reg)
        ohb_pkg::OHB_H_IDLE: begin
          if (start) begin
            mode_reg <= bus_mode;
            rd_reg <= is_read & (m68 | m80);
            dc_reg <= is_data;
            ph_reg <= 2'h0;
            cnt_reg <= 5'h00;
            div_reg <= 2'h0;
            nack_reg <= 1'b0;
            sh_reg <= mi2c ? i2c_frame : (mser ? {is_data, wbyte, 18'h0} : {19'h0, wbyte});
            if (m68 | m80) st_reg <= ohb_pkg::OHB_H_PAR;
            else if (mser) st_reg <= ohb_pkg::OHB_H_SER;
            else if (mi2c) st_reg <= ohb_pkg::OHB_H_I2C;
            else st_reg <= ohb_pkg::OHB_H_DONE;
          end
        end
        ohb_pkg::OHB_H_PAR: begin
          if (tick) begin
            ph_reg <= ph_reg + 2'h1;
            // sample read data near the end of the strobe
            if (ph_reg == 2'h2 && rd_reg) begin
              if (!nib) rbyte_reg <= pins.lvl;
              else if (cnt_reg[0]) rbyte_reg[3:0] <= pins.lvl[7:4];
              else rbyte_reg[7:4] <= pins.lvl[7:4];
            end
            // high nibble first, then low nibble
            if (ph_reg == 2'h3) begin
              if (nib && !cnt_reg[0]) cnt_reg <= 5'h01; // R18
              else st_reg <= ohb_pkg::OHB_H_DONE;
            end
          end
        end
        ohb_pkg::OHB_H_SER: begin
          if (tick) begin
            ph_reg <= {1'b0, ~ph_reg[0]};
            if (ph_reg[0]) begin
              sh_reg <= {sh_reg[25:0], 1'b0};
              cnt_reg <= cnt_reg + 5'h01;
              if (cnt_reg == {1'b0, `OHB_SER_LAST}) st_reg <= ohb_pkg::OHB_H_DONE;
            end
          end
        end
        ohb_pkg::OHB_H_I2C: begin
          if (tick) begin
            if (cnt_reg == `OHB_I2C_STOP) begin
              ph_reg <= ph_reg + 2'h1;
              if (ph_reg == 2'h2) st_reg <= ohb_pkg::OHB_H_DONE;
            end else if (ph_reg[0]) begin
              ph_reg <= 2'h0;
              cnt_reg <= cnt_reg + 5'h01;
              if (bit_slot) sh_reg <= {sh_reg[25:0], 1'b1};
              if (ack_slot && pins.sda) nack_reg <= 1'b1;
            end else begin
              ph_reg <= 2'h1;
            end
          end
        end
        ohb_pkg::OHB_H_DONE: st_reg <= ohb_pkg::OHB_H_IDLE;
      endcase
    end
  end
  // pins come from flops so the device never sees a glitch
  always_ff @(posedge clock) begin
    if (rst) begin
      cs_n_reg <= 1'b1;
      dcp_reg <= 1'b0;
      rw_reg <= 1'b0;
      e_reg <= 1'b0;
      rst_n_reg <= 1'b0;
      hout_reg <= 8'h00;
      hoe_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      cs_n_reg <= cs_n_next;
      dcp_reg <= dcp_next;
      rw_reg <= rw_next;
      e_reg <= e_next;
      rst_n_reg <= ~dev_reset; // R4
      hout_reg <= hout_next;
      hoe_reg <= hoe_next;
      done_reg <= st_reg == ohb_pkg::OHB_H_DONE;
    end
  end
  assign pins.cs_n = cs_n_reg;
  assign pins.data_cmd_sel = dcp_reg;
  assign pins.rw_wr_n = rw_reg;
  assign pins.e_rd_n = e_reg;
  assign pins.reset_in_n = rst_n_reg;
  assign pins.h_out = hout_reg;
  assign pins.h_oe = hoe_reg;
  assign busy = st_reg != ohb_pkg::OHB_H_IDLE;
  assign done = done_reg;
  assign rbyte = rbyte_reg;
  assign nack = nack_reg;
endmodule

// ===== ohb_device.sv
// display end: bus mode decode, byte capture and strap handling
`timescale 1ns/1ps
`include "ohb_map.svh"
module ohb_device (
  input wire logic clock, // 40 mhz system clock
  input wire logic rst, // synchronous reset, high
  ohb_if.dev pins, // display bus pins
  input wire logic [2:0] bus_select_straps, // bus mode straps
  input wire logic font_rom_sel_lo, // font strap, low bit
  input wire logic font_rom_sel_hi, // font strap, high bit
  input wire logic row_scan_dir_strap, // 1 first-to-last rows
  input wire logic col_scan_dir_strap, // 1 ascending columns
  input wire logic font_sw_c, // software font choice, 1 = font c
  input wire logic [7:0] rd_data, // byte offered to host reads
  input wire logic [4:0] row_idx, // logical row
  input wire logic [6:0] col_idx, // logical column
  output logic init_active, // initialization running
  output logic mode_invalid, // straps hold an invalid code
  output logic font_c, // 1 font c, 0 font a
  output logic wr_valid, // pulse: byte received
  output logic wr_is_data, // byte is display data
  output logic [7:0] wr_byte, // received byte
  output logic [7:0] cmd_byte, // command register
  output logic rd_taken, // pulse: host finished a read
  output logic [4:0] row_drv, // physical row driver
  output logic [6:0] col_drv // physical column driver
);
  logic [2:0] bs_reg;
  logic [1:0] font_reg;
  logic row_dir_reg, col_dir_reg;
  logic init_reg;
  logic wr_prev, rd_prev;
  logic [7:0] dlat_reg;
  logic dclat_reg;
  logic nib_reg;
  logic [3:0] hi_reg;
  logic scl_prev, sda_prev;
  logic [3:0] ser_cnt;
  logic [8:0] ser_sh;
  ohb_pkg::ohb_i2c_t ist_reg;
  logic [3:0] i_cnt;
  logic [7:0] i_sh;
  logic i_dc;
  logic ack_pend, ack_drv;
  logic [7:0] vout_reg, voe_reg;
  logic wr_valid_reg, wr_dc_reg, rd_taken_reg;
  logic [7:0] wr_byte_reg, cmd_reg;
  logic font_c_reg;
  logic [4:0] row_reg;
  logic [6:0] col_reg;
  // ****************************************************************
  // initialization and straps
  // ****************************************************************
  // the reset pin acts like a reset of the front end except for the font and scan mapping registers
  wire hold = rst | ~pins.reset_in_n; // R4
  // straps are sampled only while held in reset, so a mid-run change is ignored
  always_ff @(posedge clock) begin
    if (hold) begin
      bs_reg <= bus_select_straps;
      font_reg <= {font_rom_sel_hi, font_rom_sel_lo};
      row_dir_reg <= row_scan_dir_strap;
      col_dir_reg <= col_scan_dir_strap;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) init_reg <= 1'b1;
    else init_reg <= ~pins.reset_in_n; // R4
  end
  // ****************************************************************
  // mode decode
  // ****************************************************************
  wire m68 = ohb_pkg::ohb_is_68(bs_reg); // R1
  wire m80 = ohb_pkg::ohb_is_80(bs_reg); // R1
  wire nib = ohb_pkg::ohb_is_nib(bs_reg); // R1
  wire mser = bs_reg == `OHB_BS_SERIAL; // R1
  wire mi2c = bs_reg == `OHB_BS_I2C; // R1
  wire bad_code = ~bs_reg[2] & bs_reg[0]; // R1
  // ****************************************************************
  // parallel 6800 / 8080
  // ****************************************************************
  wire sel = ~pins.cs_n; // R2
  // 6800: enable high with direction low writes; 8080: write strobe low
  wire wr_act = sel & (m68 ? (pins.e_rd_n & ~pins.rw_wr_n) : (m80 & ~pins.rw_wr_n)); // R9 R10 R17
  // 6800: enable high with direction high reads; 8080: read strobe low
  wire rd_act = sel & (m68 ? (pins.e_rd_n & pins.rw_wr_n) : (m80 & ~pins.e_rd_n)); // R9 R17
  wire wr_end = wr_prev & ~wr_act;
  wire rd_end = rd_prev & ~rd_act;
  // a 4-bit byte completes on its second nibble only
  wire par_emit = wr_end & (~nib | nib_reg); // R18
  wire [7:0] par_byte = nib ? {hi_reg, dlat_reg[7:4]} : dlat_reg; // R18
  wire [7:0] rd_val = nib ? {(nib_reg ? rd_data[3:0] : rd_data[7:4]), 4'h0} : rd_data; // R18
  wire [7:0] rd_mask = nib ? 8'hf0 : 8'hff;
  // data is taken at the strobe's trailing edge, the last sample still held
  always_ff @(posedge clock) begin
    if (hold) begin
      wr_prev <= 1'b0;
      rd_prev <= 1'b0;
      dlat_reg <= 8'h00;
      dclat_reg <= 1'b0;
      nib_reg <= 1'b0;
      hi_reg <= 4'h0;
    end else begin
      wr_prev <= wr_act;
      rd_prev <= rd_act;
      if (wr_act) dlat_reg <= pins.lvl;
      if (wr_act) dclat_reg <= pins.data_cmd_sel;
      if (nib && (wr_end || rd_end)) nib_reg <= ~nib_reg; // R18
      if (wr_end && !nib_reg) hi_reg <= dlat_reg[7:4]; // R18
    end
  end
  // ****************************************************************
  // serial: d0 clock, d1 data, nine bits per frame
  // ****************************************************************
  wire sclk = pins.lvl[0]; // R12
  wire ser_rise = mser & sel & sclk & ~scl_prev; // R12
  wire ser_emit = ser_rise & (ser_cnt == `OHB_SER_LAST);
  always_ff @(posedge clock) begin
    if (hold) begin
      ser_cnt <= 4'h0;
      ser_sh <= 9'h000;
    end else if (!sel) begin
      ser_cnt <= 4'h0; // deselect resyncs the frame
    end else if (ser_rise) begin
      ser_sh <= {ser_sh[7:0], pins.lvl[1]}; // R12
      ser_cnt <= (ser_cnt == `OHB_SER_LAST) ? 4'h0 : ser_cnt + 4'h1;
    end
  end
  // ****************************************************************
  // i2c: scl on d0, sda on joined d1/d2, write-only slave
  // ****************************************************************
  wire scl = pins.lvl[0]; // R13
  wire i_start = mi2c & scl & scl_prev & sda_prev & ~pins.sda; // R13
  wire i_stop = mi2c & scl & scl_prev & ~sda_prev & pins.sda;
  wire i_rise = mi2c & scl & ~scl_prev;
  wire i_fall = mi2c & ~scl & scl_prev;
  wire [7:0] i_byte = {i_sh[6:0], pins.sda};
  wire i_last = i_rise & (i_cnt == 4'h7);
  // address lsb follows the data/command pin level
  wire i_match = i_byte[7:1] == {`OHB_I2C_ADDR_HI, pins.data_cmd_sel} & ~i_byte[0]; // R7
  wire i_emit = i_last & (ist_reg == ohb_pkg::OHB_I_DATA);
  always_ff @(posedge clock) begin
    if (hold) begin
      ist_reg <= ohb_pkg::OHB_I_IDLE;
      i_cnt <= 4'h0;
      i_sh <= 8'h00;
      i_dc <= 1'b0;
      ack_pend <= 1'b0;
      ack_drv <= 1'b0;
    end else if (i_start) begin
      ist_reg <= ohb_pkg::OHB_I_ADDR;
      i_cnt <= 4'h0;
      ack_drv <= 1'b0;
    end else if (i_stop) begin
      ist_reg <= ohb_pkg::OHB_I_IDLE;
      ack_drv <= 1'b0;
    end else begin
      if (i_rise) begin
        i_cnt <= (i_cnt == 4'h8) ? 4'h0 : i_cnt + 4'h1;
        if (i_cnt != 4'h8) i_sh <= i_byte;
      end
      if (i_last) begin
        unique case (ist_reg)
          ohb_pkg::OHB_I_IDLE: ack_pend <= 1'b0;
          ohb_pkg::OHB_I_ADDR: begin
            ack_pend <= i_match;
            ist_reg <= i_match ? ohb_pkg::OHB_I_CTRL : ohb_pkg::OHB_I_IDLE;
          end
          ohb_pkg::OHB_I_CTRL: begin
            ack_pend <= 1'b1;
            i_dc <= i_byte[`OHB_I2C_DC_BIT];
            ist_reg <= ohb_pkg::OHB_I_DATA;
          end
          ohb_pkg::OHB_I_DATA: ack_pend <= 1'b1;
        endcase
      end
      // pull sda low from the falling edge after bit 8 to the next one
      if (i_fall) ack_drv <= (i_cnt == 4'h8) & ack_pend; // R13
    end
  end
  // ****************************************************************
  // pin drive, edge history and received byte
  // ****************************************************************
  // the bus output is registered, so read data appears a cycle after the strobe
  wire [7:0] voe_next = rd_act ? rd_mask : (ack_drv ? 8'h04 : 8'h00);
  wire [7:0] vout_next = rd_act ? rd_val : 8'h00;
  wire any_emit = par_emit | ser_emit | i_emit;
  wire [7:0] emit_byte = par_emit ? par_byte :
                         ser_emit ? {ser_sh[6:0], pins.lvl[1]} : i_byte;
  // data/command: pin level in parallel, lead bit in serial, control in i2c
  wire emit_dc = par_emit ? dclat_reg : (ser_emit ? ser_sh[7] : i_dc); // R5 R6
  always_ff @(posedge clock) begin
    if (hold) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      vout_reg <= 8'h00;
      voe_reg <= 8'h00;
      wr_valid_reg <= 1'b0;
      wr_dc_reg <= 1'b0;
      wr_byte_reg <= 8'h00;
      cmd_reg <= 8'h00;
      rd_taken_reg <= 1'b0;
    end else begin
      scl_prev <= pins.lvl[0];
      sda_prev <= pins.sda;
      vout_reg <= vout_next;
      voe_reg <= voe_next;
      wr_valid_reg <= any_emit;
      rd_taken_reg <= rd_end & (~nib | nib_reg);
      if (any_emit) wr_byte_reg <= emit_byte;
      if (any_emit) wr_dc_reg <= emit_dc; // R5
      if (any_emit && !emit_dc) cmd_reg <= emit_byte; // R6
    end
  end
  // ****************************************************************
  // font and scan mapping
  // ****************************************************************
  // unlisted strap code 01 falls back to font a
  wire font_next = (font_reg == `OHB_FONT_C_CODE) |
                   ((font_reg == `OHB_FONT_SW_CODE) & font_sw_c); // R14
  always_ff @(posedge clock) begin
    if (rst) begin
      font_c_reg <= 1'b0;
      row_reg <= 5'h00;
      col_reg <= 7'h00;
    end else begin
      font_c_reg <= font_next;
      row_reg <= row_dir_reg ? row_idx : `OHB_ROW_LAST - row_idx; // R15
      col_reg <= col_dir_reg ? col_idx : `OHB_COL_LAST - col_idx; // R16
    end
  end
  assign pins.v_out = vout_reg;
  assign pins.v_oe = voe_reg;
  assign init_active = init_reg;
  assign mode_invalid = bad_code;
  assign font_c = font_c_reg;
  assign wr_valid = wr_valid_reg;
  assign wr_is_data = wr_dc_reg;
  assign wr_byte = wr_byte_reg;
  assign cmd_byte = cmd_reg;
  assign rd_taken = rd_taken_reg;
  assign row_drv = row_reg;
  assign col_drv = col_reg;
endmodule

// ===== ohb_checker.sv
// assertion checker watching the pins between the two ends
`timescale 1ns/1ps
module ohb_checker (
  input wire logic clock, // system clock
  input wire logic rst, // sync reset, high
  input wire logic cs_n, // chip select, low active
  input wire logic rw_wr_n, // direction or write strobe
  input wire logic e_rd_n, // enable or read strobe
  input wire logic reset_in_n, // display reset, low active
  input wire logic [7:0] h_out, // host data
  input wire logic [7:0] h_oe, // host enables
  input wire logic [7:0] v_out, // device data
  input wire logic [7:0] v_oe, // device enables
  input wire logic sda // joined sda line
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // ****************************************************************
  // pin relations
  // ****************************************************************
  rst_idle_a: assert property ($fell(rst) |-> cs_n && !reset_in_n && h_oe == 8'h00)
    else $error("pins not idle at reset release");
  one_driver_a: assert property ((h_oe & v_oe) == 8'h00)
    else $error("host and device drive one line");
  dev_quiet_a: assert property (cs_n [*3] |-> v_oe == 8'h00)
    else $error("device drives while deselected");
  host_quiet_a: assert property (cs_n [*2] |-> h_oe == 8'h00)
    else $error("host drives while deselected");
  init_quiet_a: assert property (!reset_in_n |=> v_oe == 8'h00)
    else $error("device drives during initialization");
  // the acknowledge is open drain: the device may only ever pull d2 low
  ack_low_a: assert property (v_oe == 8'h04 |-> !v_out[2] && !sda)
    else $error("acknowledge does not pull sda low");
  // a strobe that is held must see steady data, or the byte is torn
  wire wr_on = !cs_n && e_rd_n && !rw_wr_n;
  wdata_hold_a: assert property (wr_on ##1 wr_on |-> $stable(h_out))
    else $error("write data moved under strobe");
  rd_sel_a: assert property ($rose(|v_oe[7:4]) |-> !$past(cs_n, 2))
    else $error("read data without prior select");
  cover property (!cs_n && $fell(rw_wr_n));
  cover property ($rose(v_oe[4]));
  cover property (v_oe[2] && !sda);
endmodule

// ===== oled_host_bus_frontend_tb.sv
// testbench joining the host end and the display end
`timescale 1ns/1ps
module oled_host_bus_frontend_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [2:0] bs = 3'h4;
  logic start = 1'b0;
  logic is_data = 1'b0;
  logic is_read = 1'b0;
  logic [7:0] wbyte = 8'h00;
  logic sa = 1'b0;
  logic dev_reset = 1'b0;
  logic [1:0] font = 2'h0;
  logic row_dir = 1'b1;
  logic col_dir = 1'b1;
  logic font_sw = 1'b0;
  logic busy, done, nack, init_active, mode_invalid, font_c, wr_valid, wr_is_data, rd_taken;
  logic [7:0] rbyte, wr_byte, cmd_byte;
  logic [4:0] row_drv;
  logic [6:0] col_drv;
  int error_cnt = 0;
  int checks = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  ohb_if u_ohb_if ();
  ohb_host u_ohb_host (.clock(clock), .rst(rst), .pins(u_ohb_if.host), .bus_mode(bs),
    .start(start), .is_data(is_data), .is_read(is_read), .wbyte(wbyte), .slave_addr_lsb(sa),
    .dev_reset(dev_reset), .busy(busy), .done(done), .rbyte(rbyte), .nack(nack));
  ohb_device u_ohb_device (.clock(clock), .rst(rst), .pins(u_ohb_if.dev),
    .bus_select_straps(bs), .font_rom_sel_lo(font[0]), .font_rom_sel_hi(font[1]),
    .row_scan_dir_strap(row_dir), .col_scan_dir_strap(col_dir), .font_sw_c(font_sw),
    .rd_data(8'h96), .row_idx(5'h03), .col_idx(7'h05), .init_active(init_active),
    .mode_invalid(mode_invalid), .font_c(font_c), .wr_valid(wr_valid),
    .wr_is_data(wr_is_data), .wr_byte(wr_byte), .cmd_byte(cmd_byte), .rd_taken(rd_taken),
    .row_drv(row_drv), .col_drv(col_drv));
  ohb_checker u_ohb_checker (.clock(clock), .rst(rst), .cs_n(u_ohb_if.cs_n),
    .rw_wr_n(u_ohb_if.rw_wr_n), .e_rd_n(u_ohb_if.e_rd_n), .reset_in_n(u_ohb_if.reset_in_n),
    .h_out(u_ohb_if.h_out), .h_oe(u_ohb_if.h_oe), .v_out(u_ohb_if.v_out),
    .v_oe(u_ohb_if.v_oe), .sda(u_ohb_if.sda));
  // ****************************************************************
  // clock, counters and helpers
  // ****************************************************************
  always #12.5 clock = ~clock;
  // count bytes and reads seen by the display end
  always @(negedge clock) begin
    if (wr_valid === 1'b1) wr_cnt <= wr_cnt + 1;
    if (rd_taken === 1'b1) rd_cnt <= rd_cnt + 1;
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // straps only latch under reset, so every mode change resets both ends
  task automatic boot(input logic [2:0] m);
    @(negedge clock);
    bs = m;
    rst = 1'b1;
    repeat (4) @(negedge clock);
    rst = 1'b0;
    wr_cnt = 0;
    rd_cnt = 0;
    repeat (4) @(negedge clock);
    chk("mode_invalid", {7'h0, m == 3'h1 || m == 3'h3}, {7'h0, mode_invalid});
  endtask
  task automatic xfer(input logic d, input logic r, input logic [7:0] b);
    int n = 0;
    @(negedge clock);
    is_data = d;
    is_read = r;
    wbyte = b;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    chk("busy", 8'h01, {7'h0, busy});
    while (done !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    chk("done", 8'h01, {7'h0, done});
    repeat (4) @(negedge clock);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_par();
    for (int i = 4; i < 8; i++) begin
      boot(i[2:0]);
      xfer(1'b0, 1'b0, 8'ha5);
      chk("cmd_byte", 8'ha5, cmd_byte);
      xfer(1'b1, 1'b0, 8'h3c);
      chk("wr_byte", 8'h3c, wr_byte);
      chk("wr_is_data", 8'h01, {7'h0, wr_is_data});
      chk("cmd_kept", 8'ha5, cmd_byte);
      xfer(1'b0, 1'b1, 8'h00);
      chk("rbyte", 8'h96, rbyte);
      chk("wr_cnt", 8'h02, wr_cnt[7:0]);
      chk("rd_cnt", 8'h01, rd_cnt[7:0]);
    end
  endtask
  task automatic t_ser();
    boot(3'h0);
    xfer(1'b1, 1'b0, 8'h5a);
    chk("ser_byte", 8'h5a, wr_byte);
    chk("ser_dc", 8'h01, {7'h0, wr_is_data});
    chk("ser_dc_pin", 8'h00, {7'h0, u_ohb_if.data_cmd_sel});
    chk("ser_rw_pin", 8'h00, {7'h0, u_ohb_if.rw_wr_n});
    xfer(1'b0, 1'b0, 8'h81);
    chk("ser_cmd", 8'h81, cmd_byte);
    chk("ser_cnt", 8'h02, wr_cnt[7:0]);
  endtask
  task automatic t_i2c();
    for (int a = 0; a < 2; a++) begin
      sa = a[0];
      boot(3'h2);
      xfer(1'b1, 1'b0, 8'hc3);
      chk("i2c_byte", 8'hc3, wr_byte);
      chk("i2c_dc", 8'h01, {7'h0, wr_is_data});
      chk("i2c_nack", 8'h00, {7'h0, nack});
      chk("i2c_cs_n", 8'h00, {7'h0, u_ohb_if.cs_n});
      chk("i2c_sa_pin", {7'h0, a[0]}, {7'h0, u_ohb_if.data_cmd_sel});
      xfer(1'b0, 1'b0, 8'h3e);
      chk("i2c_cmd", 8'h3e, cmd_byte);
    end
  endtask
  task automatic t_bad();
    for (int m = 1; m < 4; m += 2) begin
      boot(m[2:0]);
      xfer(1'b0, 1'b0, 8'h77);
      chk("bad_cnt", 8'h00, wr_cnt[7:0]);
    end
  endtask
  task automatic t_strap();
    for (int k = 0; k < 8; k++) begin
      font = k[1:0];
      font_sw = k[2];
      row_dir = k[0];
      col_dir = k[1];
      boot(3'h6);
      chk("font_c", {7'h0, k[1:0] == 2'h2 || (k[1:0] == 2'h3 && k[2])}, {7'h0, font_c});
      chk("row_drv", k[0] ? 8'h03 : 8'h1c, {3'h0, row_drv});
      chk("col_drv", k[1] ? 8'h05 : 8'h5e, {1'h0, col_drv});
    end
  endtask
  task automatic t_rst();
    boot(3'h4);
    dev_reset = 1'b1;
    repeat (4) @(negedge clock);
    chk("init_on", 8'h01, {7'h0, init_active});
    dev_reset = 1'b0;
    repeat (4) @(negedge clock);
    chk("init_off", 8'h00, {7'h0, init_active});
    xfer(1'b0, 1'b0, 8'h42);
    chk("post_init", 8'h42, cmd_byte);
  endtask
  task automatic end_of_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    t_par();
    t_ser();
    t_i2c();
    t_bad();
    t_strap();
    t_rst();
    end_of_test();
  end
  // watchdog, far beyond the few thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    end_of_test();
  end
endmodule
